// ==== core/pmsp_stats_mgmt.sv ====
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module pmsp_stats_mgmt
   import pmsp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic [SNR_W+3:0] snrMarginQuarterDb,
   input wire logic encapErrPulse,
   input wire logic crcErrPulse,
   input wire logic fecFixedPulse,
   input wire logic fecLostPulse,
   input wire logic is10PassTs,
   input wire logic phyEndOffice,
   input wire logic linkUp,
   input wire logic [1:0] achievedStateIn,
   input wire logic [PROF_W-1:0] achievedProfileIn,
   output logic useIndividualConfig,
   output logic [PROF_W*NUM_PROF-1:0] selectedProfileList,
   output logic irqOut
);
   logic [CNT_W-1:0] encapCount;
   logic [CNT_W-1:0] crcCount;
   logic [CNT_W-1:0] fixedCount;
   logic [CNT_W-1:0] lostCount;
   logic [PROF_W-1:0] profile_r [NUM_PROF];
   logic [SNR_W-1:0] snrDb_r;
   logic [1:0] achState_r;
   logic [PROF_W-1:0] achNum_r;
   logic [IRQ_W-1:0] irqStat_r;
   logic [IRQ_W-1:0] irqMask_r;
   logic [IRQ_W-1:0] events;
   logic fecOk;
   logic profWriteOk;
   logic allZero;
   logic [31:0] rdMux;

   // register hit test shared by all write decodes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // pack two profile entries into one read word
   function automatic logic [31:0] packPair(input logic [PROF_W-1:0] hi,
                                            input logic [PROF_W-1:0] lo);
      packPair = {hi, lo};
   endfunction

   // 32 bit counters wrap after years at these rates, far above need
   assign fecOk = is10PassTs;
   pmsp_counter uEncap (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bump(encapErrPulse),
      .count(encapCount)
   );
   pmsp_counter uCrc (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bump(crcErrPulse),
      .count(crcCount)
   );
   pmsp_counter uFixed (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bump(fecFixedPulse && fecOk),
      .count(fixedCount)
   );
   pmsp_counter uLost (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .bump(fecLostPulse && fecOk),
      .count(lostCount)
   );

   // margin arrives in quarter dB; dropping two bits truncates downward
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         snrDb_r <= '0;
      end else begin
         snrDb_r <= snrMarginQuarterDb[SNR_W+1:2];
      end
   end

   // achieved state and number sampled together so a read is coherent
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         achState_r <= 2'(PS_NO_LINK);
         achNum_r <= PROF_ZERO;
      end else begin
         achState_r <= linkUp ? achievedStateIn : 2'(PS_NO_LINK);
         achNum_r <= achievedProfileIn;
      end
   end

   // profile writes gated by office side and link down
   assign profWriteOk = regWrite && phyEndOffice && !linkUp;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_PROF; i++) begin
            profile_r[i] <= PROF_ZERO;
         end
      end else if (profWriteOk) begin
         if (hit(regAddr, ADDR_PROF01)) begin
            profile_r[0] <= regWrData[PROF_W-1:0];
            // one entry only on 10PASS-TS
            profile_r[1] <= is10PassTs ? PROF_ZERO : regWrData[31:PROF_W];
         end
         if (hit(regAddr, ADDR_PROF23) && !is10PassTs) begin
            profile_r[2] <= regWrData[PROF_W-1:0];
            profile_r[3] <= regWrData[31:PROF_W];
         end
         if (hit(regAddr, ADDR_PROF45) && !is10PassTs) begin
            profile_r[4] <= regWrData[PROF_W-1:0];
            profile_r[5] <= regWrData[31:PROF_W];
         end
      end
   end

   // all-zero list selects individual configuration
   always_comb begin
      allZero = 1'b1;
      for (int i = 0; i < NUM_PROF; i++) begin
         if (profile_r[i] != PROF_ZERO) begin
            allZero = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         useIndividualConfig <= 1'b1;
         selectedProfileList <= '0;
      end else begin
         useIndividualConfig <= allZero;
         for (int i = 0; i < NUM_PROF; i++) begin
            selectedProfileList[i*PROF_W +: PROF_W] <= profile_r[i];
         end
      end
   end

   // sticky status: set beats write-one-to-clear in the same cycle
   assign events = {fecLostPulse && fecOk, fecFixedPulse && fecOk,
                    crcErrPulse, encapErrPulse};
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqStat_r <= IRQ_NONE;
      end else if (regWrite && hit(regAddr, ADDR_IRQ_STAT)) begin
         irqStat_r <= (irqStat_r & ~regWrData[IRQ_W-1:0]) | events;
      end else begin
         irqStat_r <= irqStat_r | events;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqMask_r <= IRQ_NONE;
      end else if (regWrite && hit(regAddr, ADDR_IRQ_MASK)) begin
         irqMask_r <= regWrData[IRQ_W-1:0];
      end
   end

   // registered so the output comes straight from a flop; one cycle late
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= |(irqStat_r & irqMask_r);
      end
   end

   // read decode; unmapped addresses read zero
   always_comb begin
      rdMux = RD_ZERO;
      unique case (regAddr)
         ADDR_SNR: rdMux = {{(32-SNR_W){1'b0}}, snrDb_r};
         ADDR_ENCAP: rdMux = encapCount;
         ADDR_CRC: rdMux = crcCount;
         ADDR_FIXED: rdMux = fixedCount;
         ADDR_LOST: rdMux = lostCount;
         ADDR_PROF01: rdMux = packPair(profile_r[1], profile_r[0]);
         ADDR_PROF23: rdMux = packPair(profile_r[3], profile_r[2]);
         ADDR_PROF45: rdMux = packPair(profile_r[5], profile_r[4]);
         ADDR_ACHIEVED: rdMux = {{(32-ACH_STATE_LSB-2){1'b0}}, achState_r, achNum_r};
         ADDR_IRQ_STAT: rdMux = {{(32-IRQ_W){1'b0}}, irqStat_r};
         ADDR_IRQ_MASK: rdMux = {{(32-IRQ_W){1'b0}}, irqMask_r};
         ADDR_CONFIG: rdMux = {{(32-2){1'b0}}, linkUp, phyEndOffice};
         default: rdMux = RD_ZERO;
      endcase
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         regRdData <= RD_ZERO;
      end else if (regRead) begin
         regRdData <= rdMux;
      end else begin
         regRdData <= RD_ZERO;
      end
   end
endmodule

// ==== core/pmsp_pkg.sv ====
package pmsp_pkg;
   // register word offsets on the plain register port
   localparam logic [7:0] ADDR_SNR = 8'h00;
   localparam logic [7:0] ADDR_ENCAP = 8'h04;
   localparam logic [7:0] ADDR_CRC = 8'h08;
   localparam logic [7:0] ADDR_FIXED = 8'h0C;
   localparam logic [7:0] ADDR_LOST = 8'h10;
   localparam logic [7:0] ADDR_PROF01 = 8'h14;
   localparam logic [7:0] ADDR_PROF23 = 8'h18;
   localparam logic [7:0] ADDR_PROF45 = 8'h1C;
   localparam logic [7:0] ADDR_ACHIEVED = 8'h20;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
   localparam logic [7:0] ADDR_CONFIG = 8'h2C;
   // widths
   localparam int CNT_W = 32;
   localparam int PROF_W = 16;
   localparam int SNR_W = 8;
   localparam int NUM_PROF = 6;
   localparam int IRQ_W = 4;
   // interrupt status bit positions
   localparam int IRQ_ENCAP = 0;
   localparam int IRQ_CRC = 1;
   localparam int IRQ_FIXED = 2;
   localparam int IRQ_LOST = 3;
   // config register bit positions
   localparam int CFG_SEQ_BIT = 0;
   // field positions inside the achieved word
   localparam int ACH_NUM_LSB = 0;
   localparam int ACH_STATE_LSB = 16;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam logic [PROF_W-1:0] PROF_ZERO = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_NONE = 4'h0;
   // achieved profile state
   typedef enum logic [1:0] {
      PS_NO_LINK,
      PS_MATCH,
      PS_NO_MATCH,
      PS_ACT_FAIL
   } pmsp_state_e;
endpackage

// ==== core/pmsp_counter.sv ====
`timescale 1ns/1ns
// free running event counter, never cleared by software, wraps at max
module pmsp_counter
   import pmsp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic bump,
   output logic [CNT_W-1:0] count
);
   // wrap instead of saturate so software can difference two reads
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         count <= '0;
      end else if (bump) begin
         count <= CNT_W'(count + CNT_ONE);
      end
   end
endmodule

// ==== sim/pmsp_stats_mgmt_properties.sv ====
`timescale 1ns/1ns
// watches the register port and the profile outputs of the stats block
module pmsp_stats_mgmt_properties
   import pmsp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData,
   input wire logic [SNR_W+3:0] snrMarginQuarterDb,
   input wire logic phyEndOffice,
   input wire logic linkUp,
   input wire logic [1:0] achievedStateIn,
   input wire logic [PROF_W-1:0] achievedProfileIn,
   input wire logic useIndividualConfig,
   input wire logic [PROF_W*NUM_PROF-1:0] selectedProfileList,
   input wire logic irqOut
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // read data stands one cycle, zero otherwise
   rd_idle_zero_a: assert property (!regRead |=> regRdData == RD_ZERO)
      else $error("read data not zero after idle cycle");
   snr_whole_db_a: assert property (regRead && regAddr == ADDR_SNR |=>
      regRdData == {24'h00_0000, $past(snrMarginQuarterDb[9:2], 2)})
      else $error("snr read wrong");
   prof_read_a: assert property (regRead && regAddr == ADDR_PROF01 && !$past(regWrite)
      |=> regRdData == $past(selectedProfileList[31:0])) else $error("profile read wrong");
   // a refused or absent write leaves the list alone, list lags register by one
   prof_locked_a: assert property (!(regWrite && phyEndOffice && !linkUp)
      |=> ##1 $stable(selectedProfileList)) else $error("profile list changed");
   cfg_all_zero_a: assert property (useIndividualConfig == (selectedProfileList == 96'h0))
      else $error("individual config flag wrong");
   state_no_link_a: assert property (regRead && regAddr == ADDR_ACHIEVED && !linkUp
      && !$past(linkUp) |=> regRdData[17:16] == PS_NO_LINK) else $error("state not no link");
   match_number_a: assert property (regRead && regAddr == ADDR_ACHIEVED && linkUp
      && $past(linkUp) && $past(reset_n) && achievedStateIn == PS_MATCH
      && $past(achievedStateIn) == PS_MATCH && $stable(achievedProfileIn)
      |=> regRdData[15:0] == $past(achievedProfileIn)) else $error("profile number wrong");
   irq_masked_a: assert property (regWrite && regAddr == ADDR_IRQ_MASK
      && regWrData[3:0] == IRQ_NONE |=> ##1 !irqOut) else $error("irq high while masked");
endmodule
bind pmsp_stats_mgmt pmsp_stats_mgmt_properties u_pmsp_stats_mgmt_properties (.*);

// ==== sim/pmsp_stats_mgmt_bench.sv ====
`timescale 1ns/1ns
// register-level tests of the stats block
module pmsp_stats_mgmt_bench
   import pmsp_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic is10 = 1'b0;
   logic office = 1'b0;
   logic linkUp = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0000_0000;
   logic [31:0] regRdData, rdVal;
   logic [3:0] ev = 4'h0;
   logic [1:0] achState = 2'h0;
   logic [11:0] snrQ = 12'h0AB;
   logic [15:0] achNum = 16'h0042;
   logic useCfg, irqOut;
   logic [95:0] profList;
   logic [7:0] cntAddr [4] = '{ADDR_ENCAP, ADDR_CRC, ADDR_FIXED, ADDR_LOST};
   logic [31:0] cntExp [4] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0002, 32'h0000_0001};
   int errors = 0;
   int total_checks = 0;
   pmsp_stats_mgmt u_pmsp_stats_mgmt (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .snrMarginQuarterDb(snrQ), .encapErrPulse(ev[0]), .crcErrPulse(ev[1]),
      .fecFixedPulse(ev[2]), .fecLostPulse(ev[3]), .is10PassTs(is10), .phyEndOffice(office),
      .linkUp(linkUp), .achievedStateIn(achState), .achievedProfileIn(achNum),
      .useIndividualConfig(useCfg), .selectedProfileList(profList), .irqOut(irqOut));
   initial forever #4 sys_clk = ~sys_clk;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      tick(1);
      regWrite <= 1'b0;
   endtask
   // sampled before the edge's own updates land, so the answer cycle is seen
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      regAddr <= a;
      regRead <= 1'b1;
      tick(1);
      regRead <= 1'b0;
      tick(1);
      rdVal = regRdData;
      check(nm, rdVal, e);
   endtask
   task automatic pulse(input logic [3:0] m, input int n);
      ev <= m;
      tick(n);
      ev <= 4'h0;
      tick(1);
   endtask
   task automatic tally_and_finish;
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, the tests need under a hundred cycles
   initial begin
      #50000;
      errors++;
      tally_and_finish();
   end
   initial begin
      tick(3);
      reset_n <= 1'b1;
      rd(ADDR_ENCAP, 32'h0000_0000, "encap");
      rd(ADDR_SNR, 32'h0000_002A, "snr");
      // back-to-back events; fec counters stay still off the 10PASS-TS type
      pulse(4'hF, 3);
      is10 <= 1'b1;
      pulse(4'h4, 2);
      pulse(4'h8, 1);
      for (int i = 0; i < 4; i++) rd(cntAddr[i], cntExp[i], "count");
      check("irq", irqOut, 0);
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      tick(2);
      check("irq", irqOut, 1);
      rd(ADDR_IRQ_STAT, 32'h0000_000F, "stat");
      wr(ADDR_IRQ_STAT, 32'h0000_0001);
      tick(2);
      check("irq", irqOut, 0);
      rd(ADDR_IRQ_STAT, 32'h0000_000E, "stat");
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      // profile writes land only on the office side with the link down
      is10 <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         office <= i[0];
         linkUp <= i[1];
         wr(ADDR_PROF01, 32'h0002_0000 + i);
         rd(ADDR_PROF01, (i == 0) ? 32'h0 : 32'h0002_0001, "prof01");
      end
      office <= 1'b1;
      linkUp <= 1'b0;
      wr(ADDR_PROF45, 32'h0006_0005);
      tick(2);
      check("list", profList[95:64], 32'h0006_0005);
      check("cfg", useCfg, 0);
      is10 <= 1'b1;
      wr(ADDR_PROF01, 32'h0007_0003);
      tick(1);
      wr(ADDR_PROF23, 32'h0000_0011);
      tick(1);
      rd(ADDR_PROF01, 32'h0000_0003, "prof01");
      rd(ADDR_PROF23, 32'h0000_0000, "prof23");
      is10 <= 1'b0;
      wr(ADDR_PROF01, 32'h0000_0000);
      tick(1);
      wr(ADDR_PROF45, 32'h0000_0000);
      tick(2);
      check("cfg", useCfg, 1);
      // achieved state and number; the number only matters on a match
      achState <= PS_MATCH;
      tick(2);
      rd(ADDR_ACHIEVED, 32'h0000_0042, "ach");
      check("state", rdVal[17:16], PS_NO_LINK);
      linkUp <= 1'b1;
      for (int s = 1; s < 4; s++) begin
         achState <= s[1:0];
         achNum <= 16'h0040 + 16'(s);
         tick(2);
         rd(ADDR_ACHIEVED, {14'h0, s[1:0], 16'h0040 + 16'(s)}, "ach");
         check("state", rdVal[17:16], s);
         if (s == 1) check("num", rdVal[15:0], 32'h0000_0041);
      end
      // 63.75 dB must read as 63, and the read-only margin ignores the write
      snrQ <= 12'h0FF;
      wr(ADDR_SNR, 32'hFFFF_FFFF);
      rd(ADDR_SNR, 32'h0000_003F, "snr");
      rd(8'h40, 32'h0000_0000, "unmapped");
      tally_and_finish();
   end
endmodule
